// file: smra_defines.svh
// smra_defines.svh: offsets, codes, field positions and times of the
// smbus memory access block.
// assumes a 200 MHz core clock; included by bare name where needed.
`ifndef SMRA_DEFINES_SVH
`define SMRA_DEFINES_SVH
`define SMRA_RAM_LAST 8'hDF
`define SMRA_RAM_BYTES 224
`define SMRA_NVM_FIRST 16'hF800
`define SMRA_NVM_LAST 16'hFBFF
`define SMRA_NVM_BYTES 1024
`define SMRA_LOCK_FIRST 16'hFA00
`define SMRA_PAGE_BYTES 32
`define SMRA_PAGE_LSB 5
`define SMRA_HI_FIRST 8'hF8
`define SMRA_HI_LAST 8'hFB
`define SMRA_CMD_BLK_WR 8'hFC
`define SMRA_CMD_BLK_RD 8'hFD
`define SMRA_CMD_ERASE 8'hFE
`define SMRA_CFG_ADDR 8'h90
`define SMRA_CFG_RESET 2'h0
`define SMRA_DEV_ADDR_HI 5'h0C
`define SMRA_BLK_LEN 6'h20
`define SMRA_PEC_SLOT 6'h21
`define SMRA_BLK_RD_COUNT 8'h20
`define SMRA_CRC_POLY 8'h07
`define SMRA_BLANK 8'hFF
`define SMRA_CLK_MHZ 200
`define SMRA_ERASE_MS 20
`define SMRA_PROG_US 250
`define SMRA_ERASE_CYC (`SMRA_ERASE_MS * 1000 * `SMRA_CLK_MHZ)
`define SMRA_PROG_CYC (`SMRA_PROG_US * `SMRA_CLK_MHZ)
`define SMRA_TMR_W 23
`endif

// file: smra_pkg.sv
// smra_pkg: types and shared decode and crc functions of the block.
// assumes smra_defines.svh is on the include path.
`include "smra_defines.svh"
package smra_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_RX, ST_WAIT, ST_ACK, ST_TX, ST_MACK, ST_IGNORE
  } smra_state_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } smra_sync_t;

  typedef struct packed {
    logic [1:0] cfg;
    logic [`SMRA_TMR_W-1:0] prog_cnt;
    logic [`SMRA_TMR_W-1:0] erase_cnt;
    logic [`SMRA_NVM_BYTES-1:0] used;
  } smra_mem_t;

  typedef struct packed {
    smra_state_t st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic sda_oe;
    logic scl_oe;
    logic drv;
    logic ack;
    logic rd;
    logic blkrd;
    logic [7:0] hi;
    logic [7:0] cmd;
    logic [5:0] idx;
    logic [5:0] cnt;
    logic [5:0] txn;
    logic [15:0] ptr;
    logic [7:0] crc;
    logic wr;
    logic erase;
    logic [15:0] waddr;
    logic [7:0] wdata;
    logic [2:0] pins1;
    logic [2:0] pins2;
    logic busy;
  } smra_top_t;

  function automatic logic is_ram(input logic [15:0] a);
    return a <= {8'h00, `SMRA_RAM_LAST};
  endfunction

  function automatic logic is_nvm(input logic [15:0] a);
    return a >= `SMRA_NVM_FIRST && a <= `SMRA_NVM_LAST;
  endfunction

  function automatic logic is_locked(input logic [15:0] a, input logic se);
    return se && a >= `SMRA_LOCK_FIRST && a <= `SMRA_NVM_LAST;
  endfunction

  // bitwise crc-8, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] dat);
    logic [7:0] r;
    r = c ^ dat;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `SMRA_CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction
endpackage

// file: smra_if.sv
// smra_if: carriers between the protocol engine and its two helpers.
// assumes one clock domain, clk_i of the top module.
`timescale 1ns/100ps
interface smra_bus_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, sda, scl_rise, scl_fall, start, stop);
  modport dst (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

interface smra_mem_if;
  logic wr;
  logic erase;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic prog_busy;
  logic erase_busy;
  logic erase_en;
  modport ctl (output wr, erase, addr, wdata,
               input rdata, prog_busy, erase_busy, erase_en);
  modport mem (input wr, erase, addr, wdata,
               output rdata, prog_busy, erase_busy, erase_en);
endinterface

// file: smra_sync.sv
// smra_sync: two-flop synchroniser for scl and sda, edge and
// start/stop detection.
// assumes the bus lines are asynchronous to clk_i.
`timescale 1ns/100ps
module smra_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  smra_bus_if.src bus
);
  smra_pkg::smra_sync_t q;
  smra_pkg::smra_sync_t d;

  // bit 1 is scl, bit 0 is sda; only s2 and s3 feed logic
  always_comb
  begin
    d = q;
    d.s1 = {scl_i, sda_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  // idle bus reads high, so reset to ones avoids a false start
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      q <= '1;
    else
      q <= d;
  end

  assign bus.scl = q.s2[1];
  assign bus.sda = q.s2[0];
  assign bus.scl_rise = q.s2[1] & ~q.s3[1];
  assign bus.scl_fall = ~q.s2[1] & q.s3[1];
  assign bus.start = q.s2[1] & q.s3[1] & ~q.s2[0] & q.s3[0];
  assign bus.stop = q.s2[1] & q.s3[1] & q.s2[0] & ~q.s3[0];
endmodule

// file: smra_mem.sv
// smra_mem: volatile byte space, nonvolatile pages with blank tracking,
// program and erase busy timers.
// assumes one request per cycle from the protocol engine.
`timescale 1ns/100ps
`include "smra_defines.svh"
module smra_mem #(
  parameter int unsigned ERASE_CYCLES = `SMRA_ERASE_CYC,
  parameter int unsigned PROG_CYCLES = `SMRA_PROG_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  smra_mem_if.mem m
);
  logic [7:0] ram [0:`SMRA_RAM_BYTES-1];
  logic [7:0] nvm [0:`SMRA_NVM_BYTES-1];
  smra_pkg::smra_mem_t q;
  smra_pkg::smra_mem_t d;
  logic [9:0] nidx;
  logic in_ram;
  logic in_nvm;
  logic is_cfg;

  assign nidx = m.addr[9:0];
  assign in_ram = smra_pkg::is_ram(m.addr);
  assign in_nvm = smra_pkg::is_nvm(m.addr);
  assign is_cfg = m.addr == {8'h00, `SMRA_CFG_ADDR};

  // timers, config bits and blank map
  always_comb
  begin
    d = q;
    if (q.prog_cnt != '0)
      d.prog_cnt = q.prog_cnt - 1'b1;
    if (q.erase_cnt != '0)
      d.erase_cnt = q.erase_cnt - 1'b1;
    // update bit self clears, so only enable bits are kept
    if (m.wr && is_cfg)
      d.cfg = {m.wdata[2], m.wdata[0]};
    if (m.wr && in_nvm && !q.used[nidx])
    begin
      d.used[nidx] = 1'b1;
      d.prog_cnt = PROG_CYCLES[`SMRA_TMR_W-1:0];
    end
    // whole page is blanked, low five address bits ignored
    if (m.erase)
    begin
      d.used[{nidx[9:`SMRA_PAGE_LSB], 5'h00} +: `SMRA_PAGE_BYTES] = '0;
      d.erase_cnt = ERASE_CYCLES[`SMRA_TMR_W-1:0];
    end
  end

  // blank map resets to all blank; contents arrays have no reset
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q <= '0;
      q.cfg <= `SMRA_CFG_RESET;
    end
    else
      q <= d;
  end

  // storage writes
  always_ff @(posedge clk_i)
  begin
    if (m.wr && in_ram)
      ram[m.addr[7:0]] <= m.wdata;
    if (m.wr && in_nvm && !q.used[nidx])
      nvm[nidx] <= m.wdata;
  end

  // a blank nvm byte reads as all ones
  assign m.rdata = is_cfg ? {5'h00, q.cfg[1], 1'b0, q.cfg[0]} :
                   in_ram ? ram[m.addr[7:0]] :
                   in_nvm ? (q.used[nidx] ? nvm[nidx] : `SMRA_BLANK) :
                   8'h00;
  assign m.prog_busy = q.prog_cnt != '0;
  assign m.erase_busy = q.erase_cnt != '0;
  assign m.erase_en = q.cfg[1];
endmodule

// file: smra_top.sv
// smra_top: smbus slave command engine for ram and nvm access,
// with clock stretching, erase busy nack and pec.
// assumes scl/sda are open drain, resolved outside from the enables.
`timescale 1ns/100ps
`include "smra_defines.svh"
module smra_top #(
  parameter int unsigned ERASE_CYCLES = `SMRA_ERASE_CYC,
  parameter int unsigned PROG_CYCLES = `SMRA_PROG_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic address_select_high_i,
  input wire logic address_select_low_i,
  input wire logic sequencing_engine_run_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic erase_busy_o
);
  smra_bus_if bus ();
  smra_mem_if mem ();
  smra_pkg::smra_top_t q;
  smra_pkg::smra_top_t d;
  logic se;
  logic hi_cmd;
  logic ram_cmd;
  logic blkwr_cmd;
  logic [5:0] last;
  logic is_data;
  logic [15:0] tgt;
  logic stall;
  logic rx_done;
  logic go;
  logic do_load;
  logic [7:0] tx_val;
  logic [7:0] crcn;

  // how the engine walks a transaction:
  // - a start condition always wins and opens the address byte,
  //   whatever state the engine was in before
  // - a stop condition returns to idle and ends any block read
  // - eight bits are shifted in on the synchronised scl rises
  // - the byte is decided at the eighth synchronised scl fall
  // - the ack is driven the clock after that fall, so the
  //   master sees sda settled well before it raises scl again
  // - the ack is released at the ninth fall, same latency
  // - after a nack the engine ignores the bus until the next
  //   start or stop, so stray bytes never reach the memory
  //
  // write side:
  // - byte index 0 is the command, later bytes depend on it
  // - a ram command alone only loads the pointer
  // - a ram command with one data byte stores it at once
  // - a high command takes the low address as its first byte
  // - a high command with a second byte programs that byte
  // - block write takes a count, then that many data bytes
  // - one byte past the data is the check byte, acked only
  //   when the running crc comes out as zero
  // - any further byte is refused
  //
  // read side:
  // - a plain read returns the byte under the pointer once
  // - a block read returns the fixed count, then the block,
  //   then the check byte if the master keeps acking
  // - the crc of a block read starts with the write part,
  //   so the check byte covers both address bytes
  //
  // hazards and limits:
  // - nvm programming is slow; rather than buffer data the
  //   engine holds scl low until the previous byte is done
  // - the stretch begins only after the byte is complete, so
  //   the master never loses a bit in flight
  // - ram writes never stretch, they land the next clock
  // - while an erase runs every address byte is refused, which
  //   is what keeps the page blank map consistent
  // - a byte that is already programmed is acked but kept;
  //   the master must erase the page first
  // - the lock range follows the synchronised engine pin, so
  //   a change takes effect two clocks after the pin moves
  // - the bus address pins are sampled the same way; change
  //   them only while the bus is idle
  // - counters saturate rather than wrap, so an overlong
  //   transaction cannot alias back onto the command byte
  //
  // timing assumptions:
  // - the core clock must run well above the scl rate; the
  //   edge detect needs several clocks per scl phase
  // - sda hold after a fall is only the sync latency, which
  //   a master of normal speed easily respects

  smra_sync u_sync (
    .clk_i (clk_i),
    .nrst_i (nrst_i),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .bus (bus.src)
  );

  smra_mem #(
    .ERASE_CYCLES (ERASE_CYCLES),
    .PROG_CYCLES (PROG_CYCLES)
  ) u_mem (
    .clk_i (clk_i),
    .nrst_i (nrst_i),
    .m (mem.mem)
  );

  // write strobes use their own address, reads follow the pointer
  assign mem.wr = q.wr;
  assign mem.erase = q.erase;
  assign mem.addr = (q.wr | q.erase) ? q.waddr : q.ptr;
  assign mem.wdata = q.wdata;

  // command decode of the current write transaction
  always_comb
  begin
    se = q.pins2[0];
    hi_cmd = q.cmd >= `SMRA_HI_FIRST && q.cmd <= `SMRA_HI_LAST;
    ram_cmd = smra_pkg::is_ram({8'h00, q.cmd});
    blkwr_cmd = q.cmd == `SMRA_CMD_BLK_WR;
    if (ram_cmd)
      last = 6'h01;
    else if (hi_cmd)
      last = 6'h02;
    else if (blkwr_cmd)
      last = q.cnt + 6'h01;
    else
      last = 6'h00;
    is_data = (ram_cmd && q.idx == 6'h01) ||
              (hi_cmd && q.idx == 6'h02) ||
              (blkwr_cmd && q.idx >= 6'h02 && q.idx <= last);
    tgt = ram_cmd ? {8'h00, q.cmd} : q.ptr;
    // stretch only for nvm data; ram writes never wait
    stall = is_data && smra_pkg::is_nvm(tgt) && mem.prog_busy;
    crcn = smra_pkg::crc8(q.crc, q.sh);
    rx_done = (q.st == smra_pkg::ST_ADDR || q.st == smra_pkg::ST_RX) &&
              bus.scl_fall && q.bits == 4'h8;
    go = (rx_done && q.st == smra_pkg::ST_RX && !stall) ||
         (q.st == smra_pkg::ST_WAIT && !stall);
    do_load = bus.scl_fall && q.ack &&
              ((q.st == smra_pkg::ST_ACK && q.rd) ||
               q.st == smra_pkg::ST_MACK);
  end

  // next byte to send on a read
  always_comb
  begin
    if (!q.blkrd)
      tx_val = (q.txn == 6'h00) ? mem.rdata : `SMRA_BLANK;
    else if (q.txn == 6'h00)
      tx_val = `SMRA_BLK_RD_COUNT;
    else if (q.txn <= `SMRA_BLK_LEN)
      tx_val = mem.rdata;
    else if (q.txn == `SMRA_PEC_SLOT)
      tx_val = q.crc;
    else
      tx_val = `SMRA_BLANK;
  end

  // protocol engine
  always_comb
  begin
    d = q;
    d.wr = 1'b0;
    d.erase = 1'b0;
    d.drv = 1'b0;
    d.pins1 = {address_select_high_i, address_select_low_i,
               sequencing_engine_run_i};
    d.pins2 = q.pins1;
    d.busy = mem.erase_busy;
    case (q.st)
      smra_pkg::ST_ADDR, smra_pkg::ST_RX:
      begin
        if (bus.scl_rise && q.bits != 4'h8)
        begin
          d.sh = {q.sh[6:0], bus.sda};
          d.bits = q.bits + 4'h1;
        end
        if (rx_done && q.st == smra_pkg::ST_RX && stall)
        begin
          d.st = smra_pkg::ST_WAIT;
          d.scl_oe = 1'b1;
        end
      end
      smra_pkg::ST_WAIT:
        d.scl_oe = 1'b1;
      smra_pkg::ST_ACK:
      begin
        // scl released one cycle after sda settles, for setup
        d.scl_oe = 1'b0;
        if (bus.scl_fall)
        begin
          d.sda_oe = 1'b0;
          d.bits = 4'h0;
          if (!q.ack)
            d.st = smra_pkg::ST_IGNORE;
          else if (!q.rd)
            d.st = smra_pkg::ST_RX;
        end
      end
      smra_pkg::ST_TX:
      begin
        if (bus.scl_fall)
        begin
          d.bits = q.bits + 4'h1;
          d.sh = {q.sh[6:0], 1'b0};
          d.sda_oe = ~q.sh[6];
          if (q.bits == 4'h7)
          begin
            d.sda_oe = 1'b0;
            d.st = smra_pkg::ST_MACK;
          end
        end
      end
      smra_pkg::ST_MACK:
      begin
        if (bus.scl_rise)
          d.ack = !bus.sda;
        // master nack ends the read
        if (bus.scl_fall && !q.ack)
          d.st = smra_pkg::ST_IGNORE;
      end
      smra_pkg::ST_IDLE, smra_pkg::ST_IGNORE:
      begin
        d.sda_oe = 1'b0;
        d.scl_oe = 1'b0;
      end
      default:
        d.st = smra_pkg::ST_IDLE;
    endcase

    // address byte: match, busy and lock checks
    if (rx_done && q.st == smra_pkg::ST_ADDR)
    begin
      d.rd = q.sh[0];
      d.txn = 6'h00;
      d.idx = 6'h00;
      if (q.sh[7:1] != {`SMRA_DEV_ADDR_HI, q.pins2[2:1]})
        d.st = smra_pkg::ST_IGNORE;
      else
      begin
        d.st = smra_pkg::ST_ACK;
        d.ack = !mem.erase_busy &&
                !(q.sh[0] && smra_pkg::is_locked(q.ptr, se));
        d.sda_oe = d.ack;
        // a block read carries the crc on from its write part
        d.crc = (q.sh[0] && q.blkrd) ? crcn :
                smra_pkg::crc8(8'h00, q.sh);
        if (!q.sh[0])
          d.blkrd = 1'b0;
      end
    end

    // received write byte, taken now or after a stretch
    if (go)
    begin
      d.st = smra_pkg::ST_ACK;
      d.crc = crcn;
      d.ack = 1'b1;
      if (q.idx != 6'h3F)
        d.idx = q.idx + 6'h01;
      if (q.idx == 6'h00)
      begin
        d.cmd = q.sh;
        if (smra_pkg::is_ram({8'h00, q.sh}))
          d.ptr = {8'h00, q.sh};
        else if (q.sh >= `SMRA_HI_FIRST && q.sh <= `SMRA_HI_LAST)
        begin
          d.hi = q.sh;
          d.ack = !smra_pkg::is_locked({q.sh, 8'h00}, se);
        end
        else if (q.sh == `SMRA_CMD_BLK_RD)
          d.blkrd = 1'b1;
        else if (q.sh == `SMRA_CMD_ERASE)
        begin
          // acked even when disabled, then has no effect
          d.erase = mem.erase_en && smra_pkg::is_nvm(q.ptr) &&
                    !smra_pkg::is_locked(q.ptr, se);
          d.waddr = q.ptr;
        end
        else
          d.ack = q.sh == `SMRA_CMD_BLK_WR;
      end
      else if (blkwr_cmd && q.idx == 6'h01)
      begin
        d.cnt = q.sh[5:0];
        d.ack = q.sh != 8'h00 && q.sh <= {2'h0, `SMRA_BLK_LEN};
      end
      else if (hi_cmd && q.idx == 6'h01)
        d.ptr = {q.hi, q.sh};
      else if (is_data)
      begin
        d.ack = !smra_pkg::is_locked(tgt, se);
        d.wr = d.ack;
        d.waddr = tgt;
        d.wdata = q.sh;
        if (blkwr_cmd)
          d.ptr = q.ptr + 16'h0001;
      end
      else
        // one check byte after the data, matching crc leaves zero
        d.ack = q.idx == last + 6'h01 && crcn == 8'h00;
      d.sda_oe = d.ack;
    end

    // load a byte for transmission after an ack
    if (do_load)
    begin
      d.sh = tx_val;
      d.sda_oe = ~tx_val[7];
      d.bits = 4'h0;
      d.st = smra_pkg::ST_TX;
      d.crc = smra_pkg::crc8(q.crc, tx_val);
      if (q.txn != 6'h3F)
        d.txn = q.txn + 6'h01;
      if (q.blkrd && q.txn != 6'h00 && q.txn <= `SMRA_BLK_LEN)
        d.ptr = q.ptr + 16'h0001;
    end

    // bus conditions override everything else
    if (bus.start)
    begin
      d.st = smra_pkg::ST_ADDR;
      d.bits = 4'h0;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
    end
    else if (bus.stop)
    begin
      d.st = smra_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
      d.blkrd = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      q <= '0;
    else
      q <= d;
  end

  // open-drain pins only ever drive low
  assign scl_o = q.drv;
  assign sda_o = q.drv;
  assign scl_oe_o = q.scl_oe;
  assign sda_oe_o = q.sda_oe;
  assign erase_busy_o = q.busy;
endmodule

// file: smra_top_props.sv
// smra_top_props: port-level checks of the smbus memory engine.
// assumes the open-drain wires are resolved outside and fed back.
`timescale 1ns/100ps
`include "smra_defines.svh"
module smra_top_props #(
  parameter int unsigned ERASE_CYCLES = `SMRA_ERASE_CYC,
  parameter int unsigned PROG_CYCLES = `SMRA_PROG_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic address_select_high_i,
  input wire logic address_select_low_i,
  input wire logic sequencing_engine_run_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic erase_busy_o
);
  logic [31:0] ecnt_q;
  logic [31:0] scnt_q;
  // length of the current erase and of the current stretch
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ecnt_q <= '0;
      scnt_q <= '0;
    end
    else
    begin
      ecnt_q <= erase_busy_o ? ecnt_q + 32'h0000_0001 : '0;
      scnt_q <= scl_oe_o ? scnt_q + 32'h0000_0001 : '0;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  property p_scl_drv;
    scl_oe_o |-> scl_o == 1'b0;
  endproperty
  a_scl_drv: assert property (p_scl_drv) else $error("scl driven high");
  property p_sda_drv;
    sda_oe_o |-> sda_o == 1'b0;
  endproperty
  a_sda_drv: assert property (p_sda_drv) else $error("sda driven high");
  // sda may only move in the low phase, else it reads as start or stop
  property p_sda_hold;
    scl_i && $past(scl_i) |-> $stable(sda_oe_o);
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("sda moved");
  property p_str_fall;
    $rose(scl_oe_o) |-> !$past(scl_i, 2);
  endproperty
  a_str_fall: assert property (p_str_fall) else $error("bad stretch");
  property p_str_len;
    scnt_q <= PROG_CYCLES + 8;
  endproperty
  a_str_len: assert property (p_str_len) else $error("stretch long");
  property p_er_min;
    $rose(erase_busy_o) |-> erase_busy_o [*8];
  endproperty
  a_er_min: assert property (p_er_min) else $error("erase short");
  property p_er_len;
    ecnt_q <= ERASE_CYCLES + 4;
  endproperty
  a_er_len: assert property (p_er_len) else $error("erase long");
  property p_er_nack;
    ecnt_q > 64 |-> !sda_oe_o;
  endproperty
  a_er_nack: assert property (p_er_nack) else $error("ack in erase");
  property p_er_start;
    $rose(erase_busy_o) |-> !scl_i;
  endproperty
  a_er_start: assert property (p_er_start) else $error("erase late");
  c_erase: cover property ($rose(erase_busy_o));
  c_stretch: cover property ($rose(scl_oe_o));
  c_ack: cover property ($rose(sda_oe_o) ##[1:20] scl_i);
endmodule
bind smra_top smra_top_props #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)
) i_props (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .address_select_high_i(address_select_high_i),
  .address_select_low_i(address_select_low_i),
  .sequencing_engine_run_i(sequencing_engine_run_i),
  .scl_o(scl_o),
  .scl_oe_o(scl_oe_o),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .erase_busy_o(erase_busy_o)
);

// file: smra_master.sv
// smra_master: smbus master model pulling scl and sda low.
// assumes a 5 ns core clock; one bit slot is 16 cycles (80 ns).
`timescale 1ns/100ps
module smra_master (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_pull_o,
  output logic sda_pull_o
);
  int stretch = 0;
  initial
  begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  task automatic q();
    repeat (4) @(negedge clk_i);
  endtask
  // data moves 4 cycles after the fall so the slave's hold is kept
  task automatic bit_io(input logic b, output logic r);
    int n;
    n = 0;
    sda_pull_o = !b;
    q();
    scl_pull_o = 1'b0;
    @(negedge clk_i);
    while (!scl_i && n < 5000)
    begin
      @(negedge clk_i);
      n++;
    end
    stretch += n;
    repeat (3) @(negedge clk_i);
    r = sda_i;
    q();
    scl_pull_o = 1'b1;
    q();
  endtask
  // also serves as repeated start from the low phase
  task automatic start();
    sda_pull_o = 1'b0;
    q();
    scl_pull_o = 1'b0;
    repeat (2) q();
    sda_pull_o = 1'b1;
    q();
    scl_pull_o = 1'b1;
    q();
  endtask
  task automatic stop();
    sda_pull_o = 1'b1;
    q();
    scl_pull_o = 1'b0;
    repeat (2) q();
    sda_pull_o = 1'b0;
    repeat (2) q();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // the master refuses the last byte it wants
  task automatic rbyte(input logic ak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(!ak, r);
  endtask
endmodule

// file: test_smbus_ram_eeprom_access.sv
// test_smbus_ram_eeprom_access: bus-level tests of the memory engine.
// assumes pull-ups on both wires; erase and program times shortened.
`timescale 1ns/100ps
module test_smbus_ram_eeprom_access;
  // bus address 01100, select high = 1, select low = 0, write bit
  localparam logic [7:0] AW = 8'h64;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sel_hi = 1'b1;
  logic sel_lo = 1'b0;
  logic se_run = 1'b0;
  logic scl_o, scl_oe, sda_o, sda_oe, ebusy, mscl, msda;
  logic [7:0] p;
  int fail_count = 0;
  int checked = 0;
  wire scl = (scl_oe ? scl_o : 1'b1) & ~mscl;
  wire sda = (sda_oe ? sda_o : 1'b1) & ~msda;
  always #2.5 clk = ~clk;
  smra_top #(.ERASE_CYCLES(2000), .PROG_CYCLES(400)) i_dut (
    .clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda),
    .address_select_high_i(sel_hi), .address_select_low_i(sel_lo),
    .sequencing_engine_run_i(se_run), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .erase_busy_o(ebusy));
  smra_master i_mst (.clk_i(clk), .scl_i(scl), .sda_i(sda),
    .scl_pull_o(mscl), .sda_pull_o(msda));
  // crc-8, polynomial 0x07, msb first
  function automatic logic [7:0] crc(input logic [7:0] c, d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // write transaction; bit i of m is the ack expected for byte i
  task automatic wr(input logic [7:0] b[$], input logic [7:0] m);
    logic [7:0] a;
    logic k;
    a = 8'h00;
    i_mst.start();
    foreach (b[i])
    begin
      i_mst.wbyte(b[i], k);
      a[i] = k;
    end
    i_mst.stop();
    chk(a, m);
  endtask
  task automatic rd1(input logic [7:0] e);
    logic [7:0] d;
    logic k;
    i_mst.start();
    i_mst.wbyte(AW | 8'h01, k);
    i_mst.rbyte(1'b0, d);
    i_mst.stop();
    chk(d, e);
  endtask
  // count, 32 bytes from the pointer, then the check byte
  task automatic blkrd(input logic [7:0] e[$]);
    logic [7:0] d;
    logic [7:0] c;
    logic k;
    c = crc(crc(crc(8'h00, AW), 8'hFD), AW | 8'h01);
    i_mst.start();
    i_mst.wbyte(AW, k);
    i_mst.wbyte(8'hFD, k);
    i_mst.start();
    i_mst.wbyte(AW | 8'h01, k);
    for (int i = 0; i < 34; i++)
    begin
      i_mst.rbyte(i < 33, d);
      if (i == 0)
        chk(d, 8'h20);
      else if (i < 33)
        chk(d, i <= e.size() ? e[i-1] : 8'hFF);
      else
        chk(d, c);
      c = crc(c, d);
    end
    i_mst.stop();
  endtask
  initial
  begin
    #400_000;
    fail_count++;
    close_out();
  end
  initial
  begin
    int n;
    n = 0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    wr('{8'h68}, 8'h00);
    wr('{AW, 8'h90}, 8'h03);
    rd1(8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr('{AW, i ? 8'hDF : 8'h00, i ? 8'h5A : 8'hA5}, 8'h07);
      wr('{AW, i ? 8'hDF : 8'h00}, 8'h03);
      rd1(i ? 8'h5A : 8'hA5);
    end
    wr('{AW, 8'hE0, 8'h01}, 8'h01);
    wr('{AW, 8'h90, 8'h07}, 8'h07);
    wr('{AW, 8'h90}, 8'h03);
    rd1(8'h05);
    wr('{AW, 8'hF8, 8'h40}, 8'h07);
    rd1(8'hFF);
    wr('{AW, 8'hF8, 8'h40, 8'h3C}, 8'h0F);
    wr('{AW, 8'hF8, 8'h40, 8'h11}, 8'h0F);
    wr('{AW, 8'hF8, 8'h40}, 8'h07);
    rd1(8'h3C);
    wr('{AW, 8'hF8, 8'h41}, 8'h07);
    i_mst.stretch = 0;
    wr('{AW, 8'hFC, 8'h03, 8'h01, 8'h02, 8'h03}, 8'h3F);
    chk(8'(i_mst.stretch > 0), 8'h01);
    wr('{AW, 8'hF8, 8'h41}, 8'h07);
    blkrd('{8'h01, 8'h02, 8'h03});
    wr('{AW, 8'hFC, 8'h00}, 8'h03);
    wr('{AW, 8'h90, 8'h00}, 8'h07);
    wr('{AW, 8'hF8, 8'h5F}, 8'h07);
    wr('{AW, 8'hFE}, 8'h03);
    wr('{AW, 8'hF8, 8'h40}, 8'h07);
    rd1(8'h3C);
    wr('{AW, 8'h90, 8'h04}, 8'h07);
    wr('{AW, 8'hF8, 8'h5F}, 8'h07);
    wr('{AW, 8'hFE}, 8'h03);
    wr('{AW}, 8'h00);
    while (ebusy && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, ebusy}, 8'h00);
    wr('{AW, 8'hF8, 8'h40}, 8'h07);
    rd1(8'hFF);
    p = crc(crc(crc(8'h00, AW), 8'h20), 8'h5A);
    wr('{AW, 8'h20, 8'h5A, p}, 8'h0F);
    wr('{AW, 8'h20, 8'h5A, ~p}, 8'h07);
    se_run = 1'b1;
    wr('{AW, 8'hFA, 8'h00}, 8'h01);
    wr('{AW, 8'hF9, 8'h00}, 8'h07);
    se_run = 1'b0;
    sel_hi = 1'b0;
    sel_lo = 1'b1;
    repeat (4) @(negedge clk);
    wr('{8'h62}, 8'h01);
    close_out();
  end
endmodule
